// [core/lss_link_status.sv]
`timescale 1ns/1ps
`default_nettype none
module lss_link_status
    import lss_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire lss_bus_t BUS,
    input wire lss_phy_t PHY,
    input wire logic UPSTREAM_COMMON_CLOCK_STRAP,
    input wire logic DOWNSTREAM_COMMON_CLOCK_STRAP,
    input wire logic INIT_LOAD,
    output logic [31:0] RDATA,
    output logic RETRAIN_REQUEST,
    output logic BW_IRQ
);
    // ------------------------------------------------------------
    // mode and control registers
    // ------------------------------------------------------------
    logic v11_reg, unlock_reg, upstream_reg;
    logic bwm_ien_reg, abw_ien_reg, dlla_cap_reg, bwn_cap_reg, slot_reg;
    logic load_ok;
    logic wr_mode, wr_ctrl, wr_lcap, wr_pcap, wr_lsts, wr_scap;

    function automatic logic hit(input lss_bus_t b, input logic [11:0] off);
        hit = b.wr && (b.addr == off);
    endfunction : hit

    assign wr_mode = hit(BUS, LSS_OFF_MODE);
    assign wr_ctrl = hit(BUS, LSS_OFF_LINK_CTRL);
    assign wr_lcap = hit(BUS, LSS_OFF_LINK_CAPS);
    assign wr_pcap = hit(BUS, LSS_OFF_PORT_CAPS);
    assign wr_lsts = hit(BUS, LSS_OFF_LINK_STATUS);
    assign wr_scap = hit(BUS, LSS_OFF_SLOT_CAPS);
    assign load_ok = INIT_LOAD || unlock_reg;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            v11_reg <= 1'b0;
            unlock_reg <= 1'b0;
            upstream_reg <= 1'b0;
        end else if (wr_mode) begin
            v11_reg <= BUS.wdata[LSS_MODE_V11_BIT];
            unlock_reg <= BUS.wdata[LSS_MODE_UNLOCK_BIT];
            upstream_reg <= BUS.wdata[LSS_MODE_UPSTREAM_BIT];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            dlla_cap_reg <= 1'b0;
            bwn_cap_reg <= 1'b0;
            slot_reg <= 1'b0;
        end else begin
            if (wr_lcap && load_ok) begin
                dlla_cap_reg <= BUS.wdata[LSS_DLLA_CAP_BIT];
                bwn_cap_reg <= BUS.wdata[LSS_BWN_CAP_BIT];
            end
            if (wr_pcap && load_ok) begin
                slot_reg <= BUS.wdata[LSS_SLOT_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // link control: interrupt enables, retrain pulse
    // ------------------------------------------------------------
    logic bw_on;
    logic retrain_reg;
    assign bw_on = bwn_cap_reg && !v11_reg;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            bwm_ien_reg <= 1'b0;
            abw_ien_reg <= 1'b0;
        end else if (!bw_on) begin
            bwm_ien_reg <= 1'b0;
            abw_ien_reg <= 1'b0;
        end else if (wr_ctrl) begin
            bwm_ien_reg <= BUS.wdata[LSS_BWM_IEN_BIT];
            abw_ien_reg <= BUS.wdata[LSS_ABW_IEN_BIT];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            retrain_reg <= 1'b0;
        end else begin
            retrain_reg <= wr_ctrl && BUS.wdata[LSS_RETRAIN_BIT] &&
                (!upstream_reg || unlock_reg);
        end
    end
    assign RETRAIN_REQUEST = retrain_reg;

    // ------------------------------------------------------------
    // retrain tracker: completion without DL_Down
    // ------------------------------------------------------------
    lss_rt_state_t rt_reg;
    logic rt_done;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rt_reg <= LSS_ST_IDLE;
        end else if (PHY.dl_down) begin
            rt_reg <= LSS_ST_IDLE;
        end else begin
            case (rt_reg)
                LSS_ST_IDLE: if (retrain_reg) rt_reg <= LSS_ST_WAIT;
                LSS_ST_WAIT: if (PHY.in_training) rt_reg <= LSS_ST_TRAIN;
                LSS_ST_TRAIN: if (PHY.retrain_done) rt_reg <= LSS_ST_IDLE;
                default: rt_reg <= LSS_ST_IDLE;
            endcase
        end
    end
    assign rt_done = (rt_reg == LSS_ST_TRAIN) && PHY.retrain_done &&
        !PHY.dl_down;

    // ------------------------------------------------------------
    // live status fields
    // ------------------------------------------------------------
    logic [3:0] speed_reg;
    logic [5:0] width_reg;
    logic train_reg, training_error_flag_reg, dlla_reg;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            speed_reg <= LSS_SPEED_RST;
            width_reg <= LSS_WIDTH_RST;
            train_reg <= 1'b0;
            dlla_reg <= 1'b0;
        end else begin
            if (PHY.speed == LSS_SPEED_2G5 || PHY.speed == LSS_SPEED_5G) begin
                speed_reg <= PHY.speed;
            end
            width_reg <= PHY.width;
            train_reg <= PHY.in_training;
            dlla_reg <= PHY.dl_active && dlla_cap_reg;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            training_error_flag_reg <= 1'b0;
        end else if (v11_reg) begin
            training_error_flag_reg <= 1'b0;
        end else if (PHY.train_fail) begin
            training_error_flag_reg <= 1'b1;
        end else if (PHY.in_training) begin
            training_error_flag_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // slot clock, strap caught after reset release
    // ------------------------------------------------------------
    logic sclk_reg, strap_done_reg;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sclk_reg <= 1'b0;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            sclk_reg <= upstream_reg ? UPSTREAM_COMMON_CLOCK_STRAP :
                DOWNSTREAM_COMMON_CLOCK_STRAP;
        end else if (wr_mode &&
            BUS.wdata[LSS_MODE_UPSTREAM_BIT] != upstream_reg) begin
            sclk_reg <= BUS.wdata[LSS_MODE_UPSTREAM_BIT] ?
                UPSTREAM_COMMON_CLOCK_STRAP :
                DOWNSTREAM_COMMON_CLOCK_STRAP;
        end else if (wr_lsts && load_ok) begin
            sclk_reg <= BUS.wdata[LSS_SCLK_BIT];
        end
    end

    // ------------------------------------------------------------
    // bandwidth status flags, set wins over clear
    // ------------------------------------------------------------
    logic ts_hit, bwm_set, abw_set, bwm_reg, abw_reg;
    lss_ts_counter u_ts (
        .SYS_CLK(SYS_CLK),
        .RST_N(RST_N),
        .ts_rx(PHY.ts_rx && !upstream_reg),
        .ts_auto_bit(PHY.ts_auto_bit),
        .hit(ts_hit)
    );
    assign bwm_set = rt_done || (PHY.reliab_change && !PHY.dl_down);
    assign abw_set = PHY.auto_change || ts_hit;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            bwm_reg <= 1'b0;
            abw_reg <= 1'b0;
        end else if (!bw_on) begin
            bwm_reg <= 1'b0;
            abw_reg <= 1'b0;
        end else begin
            bwm_reg <= bwm_set ||
                (bwm_reg && !(wr_lsts && BUS.wdata[LSS_BWM_BIT]));
            abw_reg <= abw_set ||
                (abw_reg && !(wr_lsts && BUS.wdata[LSS_ABW_BIT]));
        end
    end

    logic irq_reg;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (bw_on && bwm_set && !bwm_reg && bwm_ien_reg)
                || (bw_on && abw_set && !abw_reg && abw_ien_reg);
        end
    end
    assign BW_IRQ = irq_reg;

    // ------------------------------------------------------------
    // slot capabilities
    // ------------------------------------------------------------
    logic [LSS_SCAP_BITS-1:0] scap_reg;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            scap_reg <= '0;
        end else if (!slot_reg) begin
            scap_reg <= '0;
        end else if (wr_scap && load_ok) begin
            scap_reg <= BUS.wdata[LSS_SCAP_BITS-1:0];
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [15:0] lsts;
    logic [31:0] rd_next, rdata_reg;
    assign lsts = {abw_reg, bwm_reg, dlla_reg, sclk_reg, train_reg,
        training_error_flag_reg, width_reg, speed_reg};
    always_comb begin
        rd_next = 32'h0000_0000;
        case (BUS.addr)
            LSS_OFF_LINK_STATUS: rd_next = {16'h0000, lsts};
            LSS_OFF_SLOT_CAPS: rd_next = {26'h0000000, scap_reg};
            LSS_OFF_LINK_CTRL: begin
                rd_next[LSS_BWM_IEN_BIT] = bwm_ien_reg;
                rd_next[LSS_ABW_IEN_BIT] = abw_ien_reg;
            end
            LSS_OFF_LINK_CAPS: begin
                rd_next[LSS_DLLA_CAP_BIT] = dlla_cap_reg;
                rd_next[LSS_BWN_CAP_BIT] = bwn_cap_reg;
            end
            LSS_OFF_PORT_CAPS: rd_next[LSS_SLOT_BIT] = slot_reg;
            LSS_OFF_MODE: begin
                rd_next[LSS_MODE_V11_BIT] = v11_reg;
                rd_next[LSS_MODE_UNLOCK_BIT] = unlock_reg;
                rd_next[LSS_MODE_UPSTREAM_BIT] = upstream_reg;
            end
            default: rd_next = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= BUS.rd ? rd_next : 32'h0000_0000;
        end
    end
    assign RDATA = rdata_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb_sys @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);

    sequence s_retrain_write;
        wr_ctrl && BUS.wdata[LSS_RETRAIN_BIT] && !upstream_reg;
    endsequence
    a_retrain_pulse: assert property (
        s_retrain_write |=> RETRAIN_REQUEST ##1 (!RETRAIN_REQUEST ||
            $past(wr_ctrl && BUS.wdata[LSS_RETRAIN_BIT])))
        else $error("retrain pulse wrong");
    a_bw_gated: assert property (
        !bw_on |=> !bwm_reg && !abw_reg)
        else $error("bw flags not gated");
    a_v11_zero: assert property (
        $past(v11_reg) && v11_reg |-> !bwm_reg && !abw_reg)
        else $error("bw flags set in 1.1 mode");
    a_bwm_set: assert property (
        bw_on && bwm_set |=> bwm_reg || !bw_on)
        else $error("bw mgmt flag lost");
    a_abw_set: assert property (
        bw_on && abw_set |=> abw_reg || !bw_on)
        else $error("auto bw flag lost");
    a_dlla_gate: assert property (
        dlla_reg |-> $past(dlla_cap_reg) && $past(PHY.dl_active))
        else $error("link active not gated");
    a_train_track: assert property (
        PHY.in_training |=> train_reg)
        else $error("training flag not set");
    a_scap_slot: assert property (
        !slot_reg |=> scap_reg == '0 || slot_reg)
        else $error("slot caps not cleared");
    a_scap_lock: assert property (
        slot_reg && !load_ok |=> $stable(scap_reg) || !slot_reg)
        else $error("locked field written");
    a_speed_legal: assert property (
        speed_reg == LSS_SPEED_2G5 || speed_reg == LSS_SPEED_5G)
        else $error("reserved speed code");
    a_irq_cause: assert property (
        BW_IRQ |-> $past(bwm_ien_reg) || $past(abw_ien_reg))
        else $error("irq without enable");
endmodule : lss_link_status
`default_nettype wire

// [core/lss_pkg.sv]
package lss_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] LSS_OFF_LINK_STATUS = 12'h052;
    localparam logic [11:0] LSS_OFF_SLOT_CAPS = 12'h054;
    localparam logic [11:0] LSS_OFF_LINK_CTRL = 12'h050;
    localparam logic [11:0] LSS_OFF_LINK_CAPS = 12'h04C;
    localparam logic [11:0] LSS_OFF_PORT_CAPS = 12'h040;
    localparam logic [11:0] LSS_OFF_MODE = 12'h0F0;
    // ------------------------------------------------------------
    // link status fields
    // ------------------------------------------------------------
    localparam int LSS_LS_LSB = 0;
    localparam int LSS_LW_LSB = 4;
    localparam int LSS_TRAINING_ERROR_FLAG_BIT = 10;
    localparam int LSS_TRAIN_BIT = 11;
    localparam int LSS_SCLK_BIT = 12;
    localparam int LSS_DLLA_BIT = 13;
    localparam int LSS_BWM_BIT = 14;
    localparam int LSS_ABW_BIT = 15;
    localparam logic [3:0] LSS_SPEED_2G5 = 4'h1;
    localparam logic [3:0] LSS_SPEED_5G = 4'h2;
    localparam logic [3:0] LSS_SPEED_RST = 4'h1;
    localparam logic [5:0] LSS_WIDTH_RST = 6'h00;
    // ------------------------------------------------------------
    // control bits of own registers
    // ------------------------------------------------------------
    localparam int LSS_RETRAIN_BIT = 5;
    localparam int LSS_BWM_IEN_BIT = 10;
    localparam int LSS_ABW_IEN_BIT = 11;
    localparam int LSS_DLLA_CAP_BIT = 20;
    localparam int LSS_BWN_CAP_BIT = 21;
    localparam int LSS_SLOT_BIT = 8;
    localparam int LSS_MODE_V11_BIT = 0;
    localparam int LSS_MODE_UNLOCK_BIT = 1;
    localparam int LSS_MODE_UPSTREAM_BIT = 2;
    localparam int LSS_SCAP_BITS = 6;
    localparam logic [3:0] LSS_TS_AUTO_COUNT = 4'h8;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } lss_bus_t;

    typedef struct packed {
        logic [3:0] speed;
        logic [5:0] width;
        logic in_training;
        logic train_fail;
        logic dl_active;
        logic dl_down;
        logic retrain_done;
        logic reliab_change;
        logic auto_change;
        logic ts_rx;
        logic ts_auto_bit;
    } lss_phy_t;

    typedef enum logic [1:0] {
        LSS_ST_IDLE = 2'b00,
        LSS_ST_WAIT = 2'b01,
        LSS_ST_TRAIN = 2'b11
    } lss_rt_state_t;
endpackage : lss_pkg

// [core/lss_ts_counter.sv]
`timescale 1ns/1ps
`default_nettype none
module lss_ts_counter
    import lss_pkg::*;
#(
    parameter logic [3:0] COUNT = LSS_TS_AUTO_COUNT
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic ts_rx,
    input wire logic ts_auto_bit,
    output logic hit
);
    if (COUNT == 4'h0) begin : g_bad_count
        $error("count must be nonzero");
    end
    // ------------------------------------------------------------
    // consecutive ordered sets with autonomous change bit
    // ------------------------------------------------------------
    logic [3:0] cnt_reg;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_reg <= 4'h0;
        end else if (ts_rx) begin
            if (!ts_auto_bit) begin
                cnt_reg <= 4'h0;
            end else if (cnt_reg != COUNT) begin
                cnt_reg <= cnt_reg + 4'h1;
            end
        end
    end
    assign hit = ts_rx && ts_auto_bit && (cnt_reg == COUNT - 4'h1);
endmodule : lss_ts_counter
`default_nettype wire

// [tb/lss_link_status_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module lss_link_status_bench
    import lss_pkg::*;
;
    // ----------
    // signals
    // ----------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    lss_bus_t bus = '0;
    logic us_strap = 1'b0;
    logic ds_strap = 1'b0;
    logic init_load = 1'b0;
    logic slow = 1'b0;
    logic [31:0] rdata;
    logic [31:0] rd_val;
    logic retrain;
    logic irq;
    lss_phy_t phy;
    int fails = 0;
    int compares = 0;
    int n_rt = 0;
    int n_irq = 0;
    int b_irq;
    int b_rt;
    logic [5:0] scap;
    logic [3:0] sp [4] = '{4'h2, 4'h3, 4'h1, 4'hF};
    logic [3:0] sp_exp = LSS_SPEED_RST;
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (retrain === 1'b1) n_rt <= n_rt + 1;
        if (irq === 1'b1) n_irq <= n_irq + 1;
    end
    lss_link_status dut (.SYS_CLK(clk), .RST_N(rst_n), .BUS(bus),
        .PHY(phy), .UPSTREAM_COMMON_CLOCK_STRAP(us_strap),
        .DOWNSTREAM_COMMON_CLOCK_STRAP(ds_strap), .INIT_LOAD(init_load),
        .RDATA(rdata), .RETRAIN_REQUEST(retrain), .BW_IRQ(irq));
    lss_phy_model phy_m (.SYS_CLK(clk), .RST_N(rst_n),
        .RETRAIN_REQUEST(retrain), .slow(slow), .phy(phy));
    // ----------
    // tasks
    // ----------
    task automatic stop_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic logic [3:0] exp_speed(input logic [3:0] s,
                                             input logic [3:0] prev);
        return (s == LSS_SPEED_2G5 || s == LSS_SPEED_5G) ? s : prev;
    endfunction : exp_speed
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask : wr
    task automatic ld(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        init_load <= 1'b1;
        wr(a, d);
        init_load <= 1'b0;
    endtask : ld
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 rd_val = rdata;
    endtask : rd
    task automatic st(input string what, input logic [31:0] m,
                      input logic [31:0] exp);
        rd(LSS_OFF_LINK_STATUS);
        check(what, rd_val & m, exp);
    endtask : st
    // ----------
    // main sequence
    // ----------
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h21C9));
        scap = 6'($urandom);
        repeat (5) @(posedge clk);
        us_strap <= 1'($urandom);
        ds_strap <= 1'($urandom);
        phy_m.phy.width <= 6'($urandom);
        rst_n <= 1'b1;
        st("reset", 32'hEC0F, 32'h1);
        st("sclk", 32'h1000, {19'h0, ds_strap, 12'h0});
        st("width", 32'h3F0, {22'h0, phy.width, 4'h0});
        ld(LSS_OFF_PORT_CAPS, 32'h100);
        ld(LSS_OFF_LINK_CAPS, 32'h0030_0000);
        ld(LSS_OFF_SLOT_CAPS, {26'h0, scap});
        wr(LSS_OFF_SLOT_CAPS, {26'h0, ~scap});
        rd(LSS_OFF_SLOT_CAPS);
        check("slot", rd_val & 32'h3F,
            {26'h0, scap});
        ld(LSS_OFF_PORT_CAPS, 32'h0);
        rd(LSS_OFF_SLOT_CAPS);
        check("no slot", rd_val & 32'h3F, 32'h0);
        ld(LSS_OFF_PORT_CAPS, 32'h100);
        wr(LSS_OFF_LINK_STATUS, {19'h0, ~ds_strap, 12'h0});
        st("sclk lock", 32'h1000, {19'h0, ds_strap, 12'h0});
        ld(LSS_OFF_LINK_STATUS, {19'h0, ~ds_strap, 12'h0});
        st("sclk load", 32'h1000, {19'h0, ~ds_strap, 12'h0});
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            phy_m.phy.speed <= sp[i];
            sp_exp = exp_speed(sp[i], sp_exp);
            st("speed", 32'hF, {28'h0, sp_exp});
        end
        @(posedge clk);
        phy_m.phy.dl_active <= 1'b1;
        st("dlla", 32'h2000, 32'h2000);
        ld(LSS_OFF_LINK_CAPS, 32'h0020_0000);
        st("dlla off", 32'h2000, 32'h0);
        ld(LSS_OFF_LINK_CAPS, 32'h0030_0000);
        wr(LSS_OFF_LINK_CTRL, 32'h0C00);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            slow <= k[0];
            b_irq = n_irq;
            b_rt = n_rt;
            wr(LSS_OFF_LINK_CTRL, 32'h0C20);
            repeat (3) @(posedge clk);
            st("training", 32'h800, 32'h800);
            check("rt pulse", n_rt, b_rt + 1);
            for (int i = 0; i < 100 && n_irq == b_irq; i++) @(posedge clk);
            st("retrained", 32'h4800, 32'h4000);
            check("bw irq", n_irq, b_irq + 1);
            wr(LSS_OFF_LINK_STATUS, 32'h4000);
            st("w1c", 32'h4000, 32'h0);
        end
        rd(LSS_OFF_LINK_CTRL);
        check("retrain rd", rd_val & 32'h20, 32'h0);
        b_irq = n_irq;
        for (int k = 1; k < 3; k++) begin
            phy_m.pulse(4'(1 << k));
            st("bw event", 32'hC000, 32'h4000 << (k - 1));
            wr(LSS_OFF_LINK_STATUS, 32'hC000);
        end
        check("ev irq", n_irq, b_irq + 2);
        phy_m.send_ts(7, 1'b1);
        phy_m.send_ts(1, 1'b0);
        phy_m.send_ts(7, 1'b1);
        st("ts seven", 32'h8000, 32'h0);
        phy_m.send_ts(1, 1'b1);
        st("ts eight", 32'h8000, 32'h8000);
        wr(LSS_OFF_LINK_STATUS, 32'h8000);
        phy_m.pulse(4'h1);
        st("training_error_flag", 32'h400, 32'h400);
        ld(LSS_OFF_LINK_CAPS, 32'h0010_0000);
        phy_m.pulse(4'h6);
        st("no notify", 32'hC000, 32'h0);
        ld(LSS_OFF_LINK_CAPS, 32'h0030_0000);
        phy_m.send_ts(1, 1'b0);
        b_rt = n_rt;
        wr(LSS_OFF_MODE, 32'h4);
        st("sclk up", 32'h1000, {19'h0, us_strap, 12'h0});
        wr(LSS_OFF_LINK_CTRL, 32'h20);
        phy_m.send_ts(8, 1'b1);
        st("ts upstream", 32'h8000, 32'h0);
        check("rt upstream", n_rt, b_rt);
        wr(LSS_OFF_MODE, 32'h6);
        wr(LSS_OFF_LINK_CTRL, 32'h20);
        repeat (2) @(posedge clk);
        check("rt unlock", n_rt, b_rt + 1);
        wr(LSS_OFF_SLOT_CAPS, {26'h0, ~scap});
        rd(LSS_OFF_SLOT_CAPS);
        check("unlock", rd_val & 32'h3F, {26'h0, ~scap});
        ld(LSS_OFF_MODE, 32'h1);
        phy_m.pulse(4'h6);
        st("old mode", 32'hC000, 32'h0);
        rd(12'h0A0);
        check("unmapped", rd_val, 32'h0);
        stop_test();
    end
endmodule : lss_link_status_bench
`default_nettype wire

// [tb/lss_phy_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lss_phy_model
    import lss_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic RETRAIN_REQUEST,
    input wire logic slow,
    output var lss_phy_t phy
);
    // ----------
    // recovery on request, then done
    // ----------
    int cnt = 0;
    initial begin
        phy = '0;
        phy.speed = 4'h1;
    end
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt <= 0;
            phy.in_training <= 1'b0;
            phy.retrain_done <= 1'b0;
        end else begin
            phy.retrain_done <= 1'b0;
            if (RETRAIN_REQUEST) begin
                cnt <= slow ? 40 : 12;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
                phy.in_training <= (cnt > 2);
                phy.retrain_done <= (cnt == 1);
            end
        end
    end
    // ----------
    // event pulses and ordered sets
    // ----------
    task automatic pulse(input logic [3:0] ev);
        @(posedge SYS_CLK);
        phy.train_fail <= ev[0];
        phy.reliab_change <= ev[1];
        phy.auto_change <= ev[2];
        phy.dl_down <= ev[3];
        @(posedge SYS_CLK);
        phy.train_fail <= 1'b0;
        phy.reliab_change <= 1'b0;
        phy.auto_change <= 1'b0;
        phy.dl_down <= 1'b0;
    endtask : pulse
    task automatic send_ts(input int n, input logic ab);
        repeat (n) begin
            @(posedge SYS_CLK);
            phy.ts_rx <= 1'b1;
            phy.ts_auto_bit <= ab;
        end
        @(posedge SYS_CLK);
        phy.ts_rx <= 1'b0;
        phy.ts_auto_bit <= ~ab;
    endtask : send_ts
endmodule : lss_phy_model
`default_nettype wire
